//--- src/rvm_pkg.sv
// package: constants, types and decoders of the regulator voltage monitor
package rvm_pkg;
   // channel counts: buck channels sit in the low bits, linear channels above
   localparam int NUM_BUCK = 7;
   localparam int NUM_LIN = 4;
   localparam int NUM_CH = NUM_BUCK + NUM_LIN;
   localparam int CODE_W = 2;
   localparam int CNT_W = 4;
   localparam int BUS_W = 32;
   localparam int BE_W = BUS_W / 8;
   localparam int ADDR_W = 5;

   // clocks and times
   localparam int CLK_HZ = 40000000;
   localparam int LOW_CLK_HZ = 100000;
   localparam int US_PER_S = 1000000;
   localparam int TICK_CYC = CLK_HZ / LOW_CLK_HZ;
   localparam int LOW_FILT_US [4] = '{5, 15, 25, 40};
   localparam int HIGH_FILT_US [4] = '{25, 50, 80, 125};
   localparam int SETTLE_US = 30;
   localparam logic [CNT_W-1:0] SETTLE_TICKS = CNT_W'(SETTLE_US * LOW_CLK_HZ / US_PER_S);

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_SECURE_ENABLE = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_LOW_TRIP = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_HIGH_TRIP = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_EVENT = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_MASK = 5'h1c;
   localparam int STAT_HIGH_LSB = 16;

   // carriers
   typedef struct packed {
      logic secure_en;
      logic [CODE_W-1:0] high_fault_filter_time;
      logic [CODE_W-1:0] low_fault_filter_time;
   } rvm_cfg_t;
   typedef struct packed {
      logic [NUM_LIN-1:0] linear_supervision_enable;
      logic [NUM_BUCK-1:0] buck_supervision_enable;
   } rvm_chan_t;
   typedef struct packed {
      logic [NUM_LIN-1:0][CODE_W-1:0] linear;
      logic [NUM_BUCK-1:0][CODE_W-1:0] buck;
   } rvm_code_t;
   localparam int CFG_W = $bits(rvm_cfg_t);
   localparam int CODES_W = $bits(rvm_code_t);

   // reset values
   localparam logic [CODE_W-1:0] LOW_FILT_RST = 2'h2;
   localparam logic [CODE_W-1:0] HIGH_FILT_RST = 2'h0;
   localparam rvm_cfg_t CFG_RST = '{secure_en: 1'b0, high_fault_filter_time: HIGH_FILT_RST,
                                    low_fault_filter_time: LOW_FILT_RST};
   localparam rvm_chan_t EN_RST = '1;
   localparam rvm_code_t TRIP_RST = '0;

   // microseconds to low clock ticks, rounded up
   function automatic logic [CNT_W-1:0] us_to_ticks(input int us);
      return CNT_W'((us * LOW_CLK_HZ + US_PER_S - 1) / US_PER_S);
   endfunction : us_to_ticks

   // filter code to tick count, low or high fault
   function automatic logic [CNT_W-1:0] filter_ticks(input logic [CODE_W-1:0] code,
                                                      input logic high);
      return high ? us_to_ticks(HIGH_FILT_US[code]) : us_to_ticks(LOW_FILT_US[code]);
   endfunction : filter_ticks
endpackage : rvm_pkg

//--- src/rvm_tick_gen.sv
// low frequency tick divider for the supervision timers
`timescale 1ns/100ps
module rvm_tick_gen #(
   parameter int DIV = rvm_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // one-cycle tick per low clock period
   output logic tick
);
   import rvm_pkg::*;

   typedef struct packed {
      logic [$clog2(DIV)-1:0] cnt;
      logic tick;
   } rvm_tick_st_t;

   localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

   rvm_tick_st_t s_r;
   rvm_tick_st_t s_nxt;

   // count cycles, pulse at wrap
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = (s_r.cnt == LAST);
      s_nxt.cnt = (s_r.cnt == LAST) ? '0 : s_r.cnt + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign tick = s_r.tick;

   property p_tick_period;
      @(posedge clk) disable iff (reset)
      tick |=> !tick [*2];
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick spacing too short");
endmodule : rvm_tick_gen

//--- src/rvm_chan_filter.sv
// one supervision channel: settling mask, regulation mask, two debounce filters
`timescale 1ns/100ps
module rvm_chan_filter (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   // control
   input wire logic enable,
   input wire logic ready,
   input wire logic [rvm_pkg::CNT_W-1:0] low_limit,
   input wire logic [rvm_pkg::CNT_W-1:0] high_limit,
   // comparators
   input wire logic cmp_low,
   input wire logic cmp_high,
   // filtered status
   output logic low_fault,
   output logic high_fault
);
   import rvm_pkg::*;

   typedef struct packed {
      logic en;
      logic [CNT_W-1:0] settle;
      logic [CNT_W-1:0] lcnt;
      logic [CNT_W-1:0] hcnt;
      logic lflt;
      logic hflt;
   } rvm_filt_st_t;

   rvm_filt_st_t s_r;
   rvm_filt_st_t s_nxt;

   // one debounce step: returns {count, flag}
   function automatic logic [CNT_W:0] step(input logic [CNT_W-1:0] cnt, input logic flt,
                                            input logic cmp, input logic [CNT_W-1:0] lim);
      logic [CNT_W:0] r;
      r = {cnt, flt};
      if (!cmp)
         r = '0;
      else if (!flt && tick)
         r = (cnt >= lim) ? {cnt, 1'b1} : {cnt + 1'b1, 1'b0};
      return r;
   endfunction : step

   // channel sequencing
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.en = enable;
      if (!enable)
         s_nxt = '0;
      else if (!s_r.en || !ready)
      begin
         s_nxt = '0;
         s_nxt.en = 1'b1;
         s_nxt.settle = SETTLE_TICKS;
      end
      else if (s_r.settle != '0)
      begin
         if (tick)
            s_nxt.settle = s_r.settle - 1'b1;
      end
      else
      begin
         {s_nxt.lcnt, s_nxt.lflt} = step(s_r.lcnt, s_r.lflt, cmp_low, low_limit);
         {s_nxt.hcnt, s_nxt.hflt} = step(s_r.hcnt, s_r.hflt, cmp_high, high_limit);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign low_fault = s_r.lflt;
   assign high_fault = s_r.hflt;

   property p_off_clears;
      @(posedge clk) disable iff (reset)
      !enable |=> !low_fault && !high_fault;
   endproperty
   a_off_clears: assert property (p_off_clears) else $error("flag kept while off");

   property p_unready_mask;
      @(posedge clk) disable iff (reset)
      enable && !ready |=> !low_fault && !high_fault && s_r.settle == SETTLE_TICKS;
   endproperty
   a_unready_mask: assert property (p_unready_mask) else $error("fault before ready");

   property p_settle_quiet;
      @(posedge clk) disable iff (reset)
      s_r.settle != '0 |-> !low_fault && !high_fault;
   endproperty
   a_settle_quiet: assert property (p_settle_quiet) else $error("fault while settling");

   property p_restart;
      @(posedge clk) disable iff (reset)
      !cmp_low |=> s_r.lcnt == '0 && !low_fault;
   endproperty
   a_restart: assert property (p_restart) else $error("filter not restarted");

   property p_rise_on_limit;
      @(posedge clk) disable iff (reset)
      $rose(high_fault) |-> $past(tick) && $past(s_r.hcnt) >= $past(high_limit);
   endproperty
   a_rise_on_limit: assert property (p_rise_on_limit) else $error("early high fault");
endmodule : rvm_chan_filter

//--- src/rvm_monitor_top.sv
// top of the regulator voltage monitor: register slave, interrupt, channel array
`timescale 1ns/100ps
module rvm_monitor_top (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // avalon-mm register slave
   input wire logic [rvm_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [rvm_pkg::BUS_W-1:0] AVS_WRITEDATA,
   input wire logic [rvm_pkg::BE_W-1:0] AVS_BYTEENABLE,
   output logic [rvm_pkg::BUS_W-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // analog comparators and regulators
   input wire logic [rvm_pkg::NUM_CH-1:0] CMP_LOW,
   input wire logic [rvm_pkg::NUM_CH-1:0] CMP_HIGH,
   input wire logic [rvm_pkg::NUM_CH-1:0] REG_READY,
   output logic [rvm_pkg::NUM_CH-1:0] SUPERVISION_ENABLE,
   output logic [rvm_pkg::CODES_W-1:0] LOW_TRIP_LEVEL_CODE,
   output logic [rvm_pkg::CODES_W-1:0] HIGH_TRIP_LEVEL_CODE,
   // fault handling
   output logic [rvm_pkg::NUM_CH-1:0] LOW_FAULT_STATUS,
   output logic [rvm_pkg::NUM_CH-1:0] HIGH_FAULT_STATUS,
   output logic IRQ
);
   import rvm_pkg::*;

   typedef struct packed {
      logic waitreq;
      logic [BUS_W-1:0] rdata;
      rvm_cfg_t cfg;
      rvm_chan_t en;
      rvm_code_t low_trip;
      rvm_code_t high_trip;
      logic [NUM_CH-1:0] low_evt;
      logic [NUM_CH-1:0] high_evt;
      logic [NUM_CH-1:0] low_msk;
      logic [NUM_CH-1:0] high_msk;
      logic irq;
   } rvm_top_st_t;

   localparam rvm_top_st_t ST_RST = '{waitreq: 1'b1, rdata: '0, cfg: CFG_RST, en: EN_RST,
                                      low_trip: TRIP_RST, high_trip: TRIP_RST,
                                      low_evt: '0, high_evt: '0, low_msk: '0,
                                      high_msk: '0, irq: 1'b0};

   rvm_top_st_t s_r;
   rvm_top_st_t s_nxt;
   logic tick;
   logic [CNT_W-1:0] low_lim;
   logic [CNT_W-1:0] high_lim;
   logic [NUM_CH-1:0] en_vec;
   logic [NUM_CH-1:0] low_st;
   logic [NUM_CH-1:0] high_st;
   logic [BUS_W-1:0] w_ctrl;
   logic [BUS_W-1:0] w_en;
   logic [BUS_W-1:0] w_ltrip;
   logic [BUS_W-1:0] w_htrip;
   logic [BUS_W-1:0] w_stat;
   logic [BUS_W-1:0] w_evt;
   logic [BUS_W-1:0] w_msk;
   logic [BUS_W-1:0] rd;
   logic [BUS_W-1:0] m;
   logic [BUS_W-1:0] clr;
   logic req;
   logic acc_wr;

   // byte-lane merge of a write into a register word
   function automatic logic [BUS_W-1:0] wmerge(input logic [BUS_W-1:0] old,
                                               input logic [BUS_W-1:0] data,
                                               input logic [BE_W-1:0] be);
      logic [BUS_W-1:0] r;
      r = old;
      for (int b = 0; b < BE_W; b++)
         if (be[b])
            r[b*8 +: 8] = data[b*8 +: 8];
      return r;
   endfunction : wmerge

   // pack a low/high channel pair into the shared status layout
   function automatic logic [BUS_W-1:0] pair_word(input logic [NUM_CH-1:0] lo,
                                                  input logic [NUM_CH-1:0] hi);
      return BUS_W'(lo) | (BUS_W'(hi) << STAT_HIGH_LSB);
   endfunction : pair_word

   // shared low clock tick
   rvm_tick_gen #(
      .DIV(TICK_CYC)
   ) u_tick (
      .clk(CLK_SYS),
      .reset(RESET),
      .tick(tick)
   );

   // shared filter times from the codes
   assign low_lim = filter_ticks(s_r.cfg.low_fault_filter_time, 1'b0);
   assign high_lim = filter_ticks(s_r.cfg.high_fault_filter_time, 1'b1);
   assign en_vec = s_r.en;

   // one filter per channel, buck channels first
   for (genvar i = 0; i < NUM_CH; i++)
   begin : g_ch
      rvm_chan_filter u_filt (
         .clk(CLK_SYS),
         .reset(RESET),
         .tick(tick),
         .enable(en_vec[i]),
         .ready(REG_READY[i]),
         .low_limit(low_lim),
         .high_limit(high_lim),
         .cmp_low(CMP_LOW[i]),
         .cmp_high(CMP_HIGH[i]),
         .low_fault(low_st[i]),
         .high_fault(high_st[i])
      );
   end

   // register words as read back
   assign w_ctrl = BUS_W'(s_r.cfg);
   assign w_en = BUS_W'(s_r.en);
   assign w_ltrip = BUS_W'(s_r.low_trip);
   assign w_htrip = BUS_W'(s_r.high_trip);
   assign w_stat = pair_word(low_st, high_st);
   assign w_evt = pair_word(s_r.low_evt, s_r.high_evt);
   assign w_msk = pair_word(s_r.low_msk, s_r.high_msk);
   assign req = AVS_READ || AVS_WRITE;
   assign acc_wr = AVS_WRITE && !s_r.waitreq;

   // bus slave, register writes, events and interrupt
   always_comb
   begin
      s_nxt = s_r;
      rd = '0;
      m = '0;
      clr = '0;
      // one wait state per request
      s_nxt.waitreq = !(req && s_r.waitreq);
      unique case (AVS_ADDRESS)
         OFF_CTRL: rd = w_ctrl;
         OFF_ENABLE: rd = w_en;
         OFF_SECURE_ENABLE: rd = w_en;
         OFF_LOW_TRIP: rd = w_ltrip;
         OFF_HIGH_TRIP: rd = w_htrip;
         OFF_STATUS: rd = w_stat;
         OFF_EVENT: rd = w_evt;
         OFF_MASK: rd = w_msk;
         default: rd = '0;
      endcase
      if (AVS_READ && s_r.waitreq)
         s_nxt.rdata = rd;
      if (acc_wr)
      begin
         m = wmerge(rd, AVS_WRITEDATA, AVS_BYTEENABLE);
         unique case (AVS_ADDRESS)
            OFF_CTRL: s_nxt.cfg = m[CFG_W-1:0];
            OFF_ENABLE:
            begin
               if (!s_r.cfg.secure_en)
                  s_nxt.en = m[NUM_CH-1:0];
            end
            OFF_SECURE_ENABLE: s_nxt.en = m[NUM_CH-1:0];
            OFF_LOW_TRIP: s_nxt.low_trip = m[CODES_W-1:0];
            OFF_HIGH_TRIP: s_nxt.high_trip = m[CODES_W-1:0];
            OFF_EVENT: clr = AVS_WRITEDATA & pair_word('1, '1);
            OFF_MASK:
            begin
               s_nxt.low_msk = m[NUM_CH-1:0];
               s_nxt.high_msk = m[STAT_HIGH_LSB +: NUM_CH];
            end
            default: ;
         endcase
      end
      // sticky events, set beats clear
      s_nxt.low_evt = (s_r.low_evt & ~clr[NUM_CH-1:0]) | low_st;
      s_nxt.high_evt = (s_r.high_evt & ~clr[STAT_HIGH_LSB +: NUM_CH]) | high_st;
      s_nxt.irq = |{s_nxt.low_evt & s_nxt.low_msk, s_nxt.high_evt & s_nxt.high_msk};
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         s_r <= ST_RST;
      else
         s_r <= s_nxt;
   end

   // outputs, all from flops
   assign AVS_READDATA = s_r.rdata;
   assign AVS_WAITREQUEST = s_r.waitreq;
   assign SUPERVISION_ENABLE = en_vec;
   assign LOW_TRIP_LEVEL_CODE = s_r.low_trip;
   assign HIGH_TRIP_LEVEL_CODE = s_r.high_trip;
   assign LOW_FAULT_STATUS = low_st;
   assign HIGH_FAULT_STATUS = high_st;
   assign IRQ = s_r.irq;

   sequence s_wr_acc(logic [ADDR_W-1:0] off);
      AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == off;
   endsequence

   sequence s_full_word;
      AVS_BYTEENABLE == '1;
   endsequence

   property p_wait_one;
      @(posedge CLK_SYS) disable iff (RESET)
      req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");

   property p_reset_vals;
      @(posedge CLK_SYS)
      RESET |=> s_r.cfg.low_fault_filter_time == LOW_FILT_RST
               && s_r.cfg.high_fault_filter_time == HIGH_FILT_RST
               && SUPERVISION_ENABLE == '1;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

   property p_secure_block;
      @(posedge CLK_SYS) disable iff (RESET)
      s_wr_acc(OFF_ENABLE) ##0 s_r.cfg.secure_en |=> $stable(SUPERVISION_ENABLE);
   endproperty
   a_secure_block: assert property (p_secure_block) else $error("plain write got in");

   property p_plain_enable;
      @(posedge CLK_SYS) disable iff (RESET)
      s_wr_acc(OFF_ENABLE) ##0 s_full_word ##0 !s_r.cfg.secure_en
         |=> SUPERVISION_ENABLE == $past(AVS_WRITEDATA[NUM_CH-1:0]);
   endproperty
   a_plain_enable: assert property (p_plain_enable) else $error("enable not written");

   property p_secure_write;
      @(posedge CLK_SYS) disable iff (RESET)
      s_wr_acc(OFF_SECURE_ENABLE) ##0 s_full_word
         |=> SUPERVISION_ENABLE == $past(AVS_WRITEDATA[NUM_CH-1:0]);
   endproperty
   a_secure_write: assert property (p_secure_write) else $error("secure write lost");

   property p_event_set;
      @(posedge CLK_SYS) disable iff (RESET)
      |low_st |=> (s_r.low_evt & $past(low_st)) == $past(low_st);
   endproperty
   a_event_set: assert property (p_event_set) else $error("event not latched");

   property p_irq_follow;
      @(posedge CLK_SYS) disable iff (RESET)
      (|(s_r.high_evt & s_r.high_msk)) |-> IRQ;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("interrupt missing");

   property p_limit_map;
      @(posedge CLK_SYS) disable iff (RESET)
      s_r.cfg.low_fault_filter_time == LOW_FILT_RST |-> low_lim == us_to_ticks(LOW_FILT_US[2]);
   endproperty
   a_limit_map: assert property (p_limit_map) else $error("filter decode wrong");

   // control word, high events, quiet interrupt, cleared status of off channels
   property p_ctrl_write;
      @(posedge CLK_SYS) disable iff (RESET)
      s_wr_acc(OFF_CTRL) ##0 s_full_word |=> s_r.cfg == $past(AVS_WRITEDATA[CFG_W-1:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control not written");

   property p_ctrl_read;
      @(posedge CLK_SYS) disable iff (RESET)
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_CTRL |-> AVS_READDATA == w_ctrl;
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

   property p_high_event_set;
      @(posedge CLK_SYS) disable iff (RESET)
      |high_st |=> (s_r.high_evt & $past(high_st)) == $past(high_st);
   endproperty
   a_high_event_set: assert property (p_high_event_set) else $error("event not latched");

   property p_irq_quiet;
      @(posedge CLK_SYS) disable iff (RESET)
      !(|(s_r.low_evt & s_r.low_msk)) && !(|(s_r.high_evt & s_r.high_msk)) |-> !IRQ;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without event");

   property p_off_status;
      @(posedge CLK_SYS) disable iff (RESET)
      ((LOW_FAULT_STATUS | HIGH_FAULT_STATUS) & ~$past(SUPERVISION_ENABLE)) == '0;
   endproperty
   a_off_status: assert property (p_off_status) else $error("status kept while off");
endmodule : rvm_monitor_top

//--- dv/rvm_analog_model.sv
// behavioural model of the per-channel comparators and regulators
`timescale 1ns/100ps
module rvm_analog_model (
   // clock
   input wire logic clk,
   // enables from the monitor and requests from the bench
   input wire logic [rvm_pkg::NUM_CH-1:0] en,
   input wire logic [rvm_pkg::NUM_CH-1:0] low_req,
   input wire logic [rvm_pkg::NUM_CH-1:0] high_req,
   input wire logic [rvm_pkg::NUM_CH-1:0] ready_req,
   // comparator and regulator outputs
   output logic [rvm_pkg::NUM_CH-1:0] cmp_low,
   output logic [rvm_pkg::NUM_CH-1:0] cmp_high,
   output logic [rvm_pkg::NUM_CH-1:0] reg_ready
);
   import rvm_pkg::*;
   logic chatter_r = 1'b0;
   // an unpowered comparator chatters every cycle instead of holding a level
   always_ff @(posedge clk)
   begin
      chatter_r <= ~chatter_r;
   end
   // powered comparators follow the bench, so the monitor must ignore the others
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         cmp_low[i] = en[i] ? low_req[i] : chatter_r;
         cmp_high[i] = en[i] ? high_req[i] : ~chatter_r;
      end
   end
   // regulation point reached as the bench says
   assign reg_ready = ready_req;
endmodule : rvm_analog_model

//--- dv/regulator_voltage_monitor_test.sv
// self-checking bench of the regulator voltage monitor
`timescale 1ns/100ps
module regulator_voltage_monitor_test;
   import rvm_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [BUS_W-1:0] wdata = '0;
   logic [BE_W-1:0] be = '1;
   logic [BUS_W-1:0] rdata;
   logic wreq;
   logic [NUM_CH-1:0] cmp_low, cmp_high, reg_ready, sup_en, low_stat, high_stat;
   logic [NUM_CH-1:0] low_req = '0;
   logic [NUM_CH-1:0] high_req = '0;
   logic [NUM_CH-1:0] ready_req = '1;
   logic [CODES_W-1:0] low_code, high_code, d;
   logic irq;
   int num_errors = 0;
   int n_checks = 0;
   int ch;
   int n;

   // 40 MHz system clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   rvm_monitor_top dut (.CLK_SYS(clk), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .CMP_LOW(cmp_low), .CMP_HIGH(cmp_high), .REG_READY(reg_ready),
      .SUPERVISION_ENABLE(sup_en), .LOW_TRIP_LEVEL_CODE(low_code),
      .HIGH_TRIP_LEVEL_CODE(high_code), .LOW_FAULT_STATUS(low_stat),
      .HIGH_FAULT_STATUS(high_stat), .IRQ(irq));
   rvm_analog_model model (.clk(clk), .en(sup_en), .low_req(low_req), .high_req(high_req),
      .ready_req(ready_req), .cmp_low(cmp_low), .cmp_high(cmp_high), .reg_ready(reg_ready));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic is_wr, input logic [ADDR_W-1:0] a,
                      input logic [BUS_W-1:0] dat, output logic [BUS_W-1:0] q);
      int k;
      @(posedge clk);
      addr <= a;
      wdata <= dat;
      if (is_wr)
         wr <= 1'b1;
      else
         rd <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (wreq !== 1'b0 && k < 50);
      if (wreq !== 1'b0)
      begin
         num_errors++;
         $display("[ERR] waitrequest expected 0 seen %b", wreq);
         report_and_stop;
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] dat);
      logic [BUS_W-1:0] q;
      bus(1'b1, a, dat, q);
   endtask : wr_reg

   task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a,
                         input logic [BUS_W-1:0] exp);
      logic [BUS_W-1:0] q;
      bus(1'b0, a, '0, q);
      check(name, q, exp);
   endtask : rd_chk

   // filter length in 10 us low clock ticks, rounded up
   function automatic int exp_ticks(input logic hi, input int code);
      int lo_us [4] = '{5, 15, 25, 40};
      int hi_us [4] = '{25, 50, 80, 125};
      return ((hi ? hi_us[code] : lo_us[code]) + 9) / 10;
   endfunction : exp_ticks

   function automatic logic flag(input logic hi, input int c);
      return hi ? high_stat[c] : low_stat[c];
   endfunction : flag

   task automatic drive(input logic hi, input int c, input logic v);
      @(posedge clk);
      if (hi)
         high_req[c] <= v;
      else
         low_req[c] <= v;
   endtask : drive

   // cycles until the fault flag rises, bounded
   task automatic wait_flag(input logic hi, input int c, input int lim, output int cnt);
      cnt = 0;
      while (flag(hi, c) !== 1'b1)
      begin
         @(posedge clk);
         cnt++;
         if (cnt > lim)
         begin
            num_errors++;
            $display("[ERR] fault flag expected 1 seen %b", flag(hi, c));
            report_and_stop;
         end
      end
   endtask : wait_flag

   // short fault, full fault, event, mask and clear for one code
   task automatic run_filter(input logic hi, input int code, input int c);
      int lim;
      int cnt;
      int pos;
      logic [BUS_W-1:0] msk;
      lim = exp_ticks(hi, code);
      pos = hi ? c + STAT_HIGH_LSB : c;
      msk = $urandom & 32'h07ff07ff;
      msk[pos] = code[0];
      wr_reg(OFF_CTRL, BUS_W'(code * 5));
      wr_reg(OFF_MASK, msk);
      repeat (4 * TICK_CYC) @(posedge clk);
      drive(hi, c, 1'b1);
      repeat (lim * TICK_CYC - TICK_CYC / 2) @(posedge clk);
      drive(hi, c, 1'b0);
      check("flag after short fault", 32'(flag(hi, c)), 32'h0);
      drive(hi, c, 1'b1);
      wait_flag(hi, c, (lim + 2) * TICK_CYC, cnt);
      check("filter delay", 32'(cnt >= lim * TICK_CYC - 8 && cnt <= (lim + 1) * TICK_CYC + 8),
            32'h1);
      rd_chk("status", OFF_STATUS, BUS_W'(1) << pos);
      rd_chk("event", OFF_EVENT, BUS_W'(1) << pos);
      check("irq", 32'(irq), 32'(code[0]));
      drive(hi, c, 1'b0);
      repeat (3) @(posedge clk);
      check("flag after fault ends", 32'(flag(hi, c)), 32'h0);
      wr_reg(OFF_EVENT, BUS_W'(1) << pos);
      rd_chk("event cleared", OFF_EVENT, 32'h0);
      check("irq cleared", 32'(irq), 32'h0);
      $display("test filter high=%0d code=%0d channel=%0d done", hi, code, c);
   endtask : run_filter

   // main sequence
   initial
   begin
      void'($urandom(32'he611));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check("enable port", 32'(sup_en), 32'h7ff);
      check("status ports", 32'({low_stat, high_stat, irq}), 32'h0);
      rd_chk("ctrl reset", OFF_CTRL, 32'h2);
      rd_chk("enable reset", OFF_ENABLE, 32'h7ff);
      rd_chk("mask reset", OFF_MASK, 32'h0);
      rd_chk("unmapped", 5'h02, 32'h0);
      $display("test reset values done");
      // every trip code on all channels, then random patterns
      for (int c = 0; c < 7; c++)
      begin
         d = (c < 4) ? {11{2'(c)}} : CODES_W'($urandom);
         wr_reg(OFF_LOW_TRIP, BUS_W'(d));
         wr_reg(OFF_HIGH_TRIP, BUS_W'(~d));
         repeat (2) @(posedge clk);
         check("low trip port", 32'(low_code), 32'(d));
         check("high trip port", 32'(high_code), 32'(CODES_W'(~d)));
         rd_chk("low trip read", OFF_LOW_TRIP, BUS_W'(d));
         rd_chk("high trip read", OFF_HIGH_TRIP, BUS_W'(CODES_W'(~d)));
      end
      $display("test trip codes done");
      // secure mode refuses ordinary enable writes
      ch = $urandom % NUM_CH;
      wr_reg(OFF_CTRL, 32'h12);
      wr_reg(OFF_ENABLE, 32'h7ff ^ (32'h1 << ch));
      repeat (2) @(posedge clk);
      check("enable in secure mode", 32'(sup_en), 32'h7ff);
      wr_reg(OFF_SECURE_ENABLE, 32'h7ff ^ (32'h1 << ch));
      repeat (2) @(posedge clk);
      check("secure enable write", 32'(sup_en), 32'h7ff ^ (32'h1 << ch));
      wr_reg(OFF_CTRL, 32'h2);
      wr_reg(OFF_ENABLE, 32'h7ff);
      repeat (2) @(posedge clk);
      check("ordinary enable write", 32'(sup_en), 32'h7ff);
      $display("test secure write done");
      // every filter code, both faults, random buck and linear channels
      for (int code = 0; code < 4; code++)
         for (int hi = 0; hi < 2; hi++)
            run_filter(1'(hi), code, $urandom % NUM_CH);
      // disable clears, enable settles, regulation masks
      ch = $urandom % NUM_CH;
      wr_reg(OFF_CTRL, 32'h0);
      drive(1'b0, ch, 1'b1);
      wait_flag(1'b0, ch, 3 * TICK_CYC, n);
      wr_reg(OFF_ENABLE, 32'h7ff ^ (32'h1 << ch));
      repeat (3) @(posedge clk);
      check("flag after disable", 32'(low_stat[ch]), 32'h0);
      repeat (TICK_CYC) @(posedge clk);
      check("disabled flag stays clear", 32'(low_stat[ch]), 32'h0);
      wr_reg(OFF_ENABLE, 32'h7ff);
      wait_flag(1'b0, ch, 8 * TICK_CYC, n);
      check("settle after enable", 32'(n > 2 * TICK_CYC + TICK_CYC / 2), 32'h1);
      @(posedge clk);
      ready_req[ch] <= 1'b0;
      repeat (3) @(posedge clk);
      check("flag out of regulation", 32'(low_stat[ch]), 32'h0);
      repeat (6 * TICK_CYC) @(posedge clk);
      check("masked out of regulation", 32'(low_stat[ch]), 32'h0);
      ready_req[ch] <= 1'b1;
      wait_flag(1'b0, ch, 8 * TICK_CYC, n);
      check("settle after regulation", 32'(n > 2 * TICK_CYC + TICK_CYC / 2), 32'h1);
      drive(1'b0, ch, 1'b0);
      wr_reg(OFF_EVENT, 32'h07ff07ff);
      rd_chk("all events cleared", OFF_EVENT, 32'h0);
      $display("test enable and regulation done");
      report_and_stop;
   end
endmodule : regulator_voltage_monitor_test
